// ==== core/home_mgr_cfg.svh ====
`ifndef HOME_MGR_CFG_SVH
`define HOME_MGR_CFG_SVH

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define HM_POS_W            32
`define HM_PRESET_RST       32'h00000000
`define HM_ABS_PERMIT_RST   1'b0
`define HM_PRIO_RST         1'b0
`define HM_OVR_RST          1'b0
`define HM_NVM_ENDURANCE    100000

`endif

// ==== core/home_mgr_pkg.sv ====
`include "home_mgr_cfg.svh"

package home_mgr_pkg;

  // ----------------------------------------------------------------------
  // move request and settings carriers
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MOVE_NONE,
    MOVE_HOMING,
    MOVE_HS_HOMING,
    MOVE_ABS
  } move_kind_t;

  typedef struct packed {
    logic abs_permit;      // 0 disable, 1 enable
    logic prio_mech;       // 0 sensor values, 1 manual
    logic prio_coord;
    logic prio_jog_home;
    logic ovr_limit;       // 0 follow sensor, 1 disable
    logic ovr_protect;
  } settings_t;

  typedef struct packed {
    logic mech_sensor;
    logic coord_sensor;
    logic jog_home_sensor;
    logic limit_on;
    logic protect_on;
  } select_t;

  typedef enum logic [1:0] {
    HOME_IDLE,
    HOME_BUSY
  } home_state_t;

endpackage

// ==== core/edge_detect.sv ====
`timescale 1ns/1ps

module edge_detect (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic level_in,
  output logic      level_q,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic prev;
  } edge_state_t;

  edge_state_t state_reg;
  edge_state_t state_next;

  // previous level, reset low so a high input at release counts as a rise
  always_comb begin
    state_next      = state_reg;
    state_next.prev = level_in;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign level_q = state_reg.prev;
  assign rise    = level_in & ~state_reg.prev;
  assign fall    = ~level_in & state_reg.prev;

endmodule

// ==== core/prio_select.sv ====
`timescale 1ns/1ps

module prio_select (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire home_mgr_pkg::settings_t settings,
  output home_mgr_pkg::select_t       select
);

  home_mgr_pkg::select_t state_reg;
  home_mgr_pkg::select_t state_next;

  // sensor-stored values win unless the host picks manual or disable
  always_comb begin
    state_next                 = state_reg;
    state_next.mech_sensor     = ~settings.prio_mech;
    state_next.coord_sensor    = ~settings.prio_coord;
    state_next.jog_home_sensor = ~settings.prio_jog_home;
    state_next.limit_on        = ~settings.ovr_limit;
    state_next.protect_on      = ~settings.ovr_protect;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= '1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign select = state_reg;

endmodule

// ==== core/coordinate_home_manager.sv ====
// Functional notes
// - coords valid output high once home set
// - unset coords refuse high-speed homing, absolute
// - absolute permission 0 disable, 1 enable
// - factory home flag from sensor, unmodifiable
// - user home flag on homing or preset
// - fieldbus cannot clear user home
// - user home commit pulses nonvolatile write
// - preset loads command and feedback positions
// - rising request captures command position
// - falling request clears electrical home
// - electrical active output mirrors electrical home
// - electrical home never written to nonvolatile
// - preset with request high sets both homes
// - electrical coordinates refuse high-speed homing
// - four cases leave coordinates unset
// - priority selects 0 sensor, 1 manual
// - override settings 0 follow, 1 disable
// - sensor values win by default
`timescale 1ns/1ps
`include "home_mgr_cfg.svh"

module coordinate_home_manager #(
  parameter int POS_W = `HM_POS_W
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,

  // settings from the host
  input  wire logic                      abs_permit,
  input  wire logic                      prio_mech,
  input  wire logic                      prio_coord,
  input  wire logic                      prio_jog_home,
  input  wire logic                      ovr_limit,
  input  wire logic                      ovr_protect,
  input  wire logic                      settings_load,
  input  wire logic signed [POS_W-1:0]   preset_value,

  // sensor state
  input  wire logic                      sensor_factory_home,
  input  wire logic                      sensor_user_home,

  // commands
  input  wire logic                      preset_cmd,
  input  wire logic                      tool_clear_cmd,
  input  wire logic                      fieldbus_clear_cmd,
  input  wire logic                      resolution_change,
  input  wire logic                      elec_home_request,
  input  wire logic signed [POS_W-1:0]   cmd_position_in,

  // move requests
  input  wire logic                      move_req,
  input  wire home_mgr_pkg::move_kind_t  move_kind,
  input  wire logic                      homing_done,
  input  wire logic                      homing_abort,

  // outputs
  output logic                           coords_valid_out,
  output logic                           factory_home_flag,
  output logic                           user_home_flag,
  output logic                           elec_home_active,
  output logic                           move_accept,
  output logic                           move_reject,
  output logic                           nvm_write,
  output logic signed [POS_W-1:0]        nvm_home_data,
  output logic                           pos_load,
  output logic signed [POS_W-1:0]        pos_load_value,
  output logic signed [POS_W-1:0]        elec_home_pos,
  output logic                           mech_sensor_sel,
  output logic                           coord_sensor_sel,
  output logic                           jog_home_sensor_sel,
  output logic                           limit_enable,
  output logic                           protect_enable
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    // host settings, latched on settings_load
    home_mgr_pkg::settings_t   settings;

    // homing progress and home bookkeeping
    home_mgr_pkg::home_state_t home_st;
    logic                      user_set;
    logic                      factory_set;
    logic                      nonzero_preset;

    // electrical home, volatile only
    logic                      elec_set;
    logic signed [POS_W-1:0]   elec_pos;

    // registered outputs
    logic                      valid;
    logic                      accept;
    logic                      reject;
    logic                      nvm_wr;
    logic signed [POS_W-1:0]   nvm_data;
    logic                      load;
    logic signed [POS_W-1:0]   load_val;
  } state_t;

  // the whole state as one register pair
  state_t state_reg;
  state_t state_next;

  // request level and edges from edge_detect
  logic                  req_level;
  logic                  req_rise;
  logic                  req_fall;

  // source selects, registered inside prio_select
  home_mgr_pkg::select_t select;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // a rise captures, a fall clears
  edge_detect u_req_edge (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .level_in (elec_home_request),
    .level_q  (req_level),
    .rise     (req_rise),
    .fall     (req_fall)
  );

  // selects follow the latched settings
  prio_select u_prio (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .settings (state_reg.settings),
    .select   (select)
  );

  // ----------------------------------------------------------------------
  // move gates
  // ----------------------------------------------------------------------
  // gates read registered state only: a move in the cycle of a
  // preset is judged on the coordinates as they stood before it
  logic home_known;
  logic hs_block;
  logic abs_block;
  logic establish;

  assign home_known = state_reg.user_set | state_reg.factory_set;
  assign hs_block   = ~state_reg.valid | state_reg.elec_set;
  assign abs_block  = ~state_reg.valid & ~state_reg.settings.abs_permit;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  // one pass builds the whole next state; later blocks override earlier
  always_comb begin
    state_next        = state_reg;
    // pulses fall back low, so each lasts one clock
    state_next.accept = 1'b0;
    state_next.reject = 1'b0;
    state_next.nvm_wr = 1'b0;
    state_next.load   = 1'b0;

    // settings take effect only when the host loads them
    // all six bits move together; there is no partial update
    if (settings_load) begin
      state_next.settings.abs_permit    = abs_permit;
      state_next.settings.prio_mech     = prio_mech;
      state_next.settings.prio_coord    = prio_coord;
      state_next.settings.prio_jog_home = prio_jog_home;
      state_next.settings.ovr_limit     = ovr_limit;
      state_next.settings.ovr_protect   = ovr_protect;
    end

    // factory home follows the sensor only; nothing here can clear it
    state_next.factory_set = sensor_factory_home;
    // the flag drops with the sensor, never by a command

    // raised below by a preset or by the end of a homing move
    establish = 1'b0;

    // move gating; homing itself invalidates coordinates while it runs
    // outcome pulses show one clock after the request
    if (move_req && state_reg.home_st == home_mgr_pkg::HOME_IDLE) begin
      case (move_kind)
        home_mgr_pkg::MOVE_HS_HOMING: begin
          // needs set coordinates on the mechanical home
          state_next.accept = ~hs_block;
          state_next.reject = hs_block;
        end
        home_mgr_pkg::MOVE_ABS: begin
          // permission lets it run on unset coordinates
          state_next.accept = ~abs_block;
          state_next.reject = abs_block;
        end
        home_mgr_pkg::MOVE_HOMING: begin
          // always allowed: it is how a home gets made
          state_next.accept  = 1'b1;
          state_next.home_st = home_mgr_pkg::HOME_BUSY;
        end
        default: begin
          // no move kind: nothing to answer
          state_next.accept = 1'b0;
        end
      endcase
    end else if (move_req) begin
      state_next.reject = 1'b1; // one homing at a time
    end

    // busy lasts until the motion core reports done or abort
    case (state_reg.home_st)
      home_mgr_pkg::HOME_BUSY: begin
        if (homing_done) begin
          state_next.home_st = home_mgr_pkg::HOME_IDLE;
          establish          = 1'b1;
        end else if (homing_abort) begin
          // the old home stays; validity returns by itself only while no nonzero preset is in force
          state_next.home_st = home_mgr_pkg::HOME_IDLE;
        end
      end
      default: begin
        // a preset during homing is dropped
        if (preset_cmd) begin
          establish = 1'b1;
        end
      end
    endcase

    // each establish costs one write to a store of limited endurance;
    // keeping presets rare is the host's job
    // homing completion lands on the preset value as well
    // user home establishment: positions, flag, nonvolatile commit
    if (establish) begin
      state_next.user_set       = 1'b1;
      state_next.nonzero_preset = (preset_value != '0);
      state_next.load           = 1'b1;
      state_next.load_val       = preset_value;
      state_next.nvm_wr         = 1'b1;
      state_next.nvm_data       = preset_value;
    end

    // electrical home lives only in these flops
    // rise and fall never meet: edge_detect sees one level
    // a fall zeroes the position so no stale home shows
    if (req_rise) begin
      state_next.elec_set = 1'b1;
      state_next.elec_pos = cmd_position_in;
    end else if (req_fall) begin
      state_next.elec_set = 1'b0;
      state_next.elec_pos = '0;
    end
    // preset with the request held: both homes take its value
    if (establish && req_level && !req_fall) begin
      state_next.elec_pos = preset_value;
    end

    // only the tool clear may unset the user home; fieldbus is ignored
    // a set in the same cycle wins over the clear
    if (tool_clear_cmd && !establish) begin
      state_next.user_set       = 1'b0;
      state_next.nonzero_preset = 1'b0;
    end

    // coordinate validity: set wins over the unsetting events
    // revalidation needs a known home, an idle homing state and no nonzero preset in force,
    // which only an establish with a zero preset value or a tool clear lifts
    if (establish) begin
      state_next.valid = 1'b1;
    end else if (state_next.home_st == home_mgr_pkg::HOME_BUSY) begin
      state_next.valid = 1'b0;
    end else if (tool_clear_cmd) begin
      state_next.valid = 1'b0;
    end else if (resolution_change && state_reg.nonzero_preset) begin
      state_next.valid = 1'b0;
    end else if (!state_reg.valid && (home_known | sensor_user_home)
                 && state_reg.home_st == home_mgr_pkg::HOME_IDLE
                 && !state_reg.nonzero_preset) begin
      state_next.valid = 1'b1;
    end
    // a home the sensor already holds is adopted once valid
    if (sensor_user_home && !tool_clear_cmd && !state_reg.user_set
        && state_reg.valid) begin
      state_next.user_set = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // one register for all state; helpers keep their own flops
  // reset is the factory-shipped view: nothing set, defaults loaded
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg                        <= '0;
      state_reg.settings.abs_permit    <= `HM_ABS_PERMIT_RST;
      state_reg.settings.prio_mech     <= `HM_PRIO_RST;
      state_reg.settings.prio_coord    <= `HM_PRIO_RST;
      state_reg.settings.prio_jog_home <= `HM_PRIO_RST;
      state_reg.settings.ovr_limit     <= `HM_OVR_RST;
      state_reg.settings.ovr_protect   <= `HM_OVR_RST;
      // idle, so the first move after reset is judged at once
      state_reg.home_st                <= home_mgr_pkg::HOME_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------------
  // home status levels
  assign coords_valid_out    = state_reg.valid;
  assign factory_home_flag   = state_reg.factory_set;
  assign user_home_flag      = state_reg.user_set;
  assign elec_home_active    = state_reg.elec_set;

  // move answers, one clock each
  assign move_accept         = state_reg.accept;
  assign move_reject         = state_reg.reject;

  // home commit and position load: pulse plus data word
  assign nvm_write           = state_reg.nvm_wr;
  assign nvm_home_data       = state_reg.nvm_data;
  assign pos_load            = state_reg.load;
  assign pos_load_value      = state_reg.load_val;

  // electrical home position, zero while none is held
  assign elec_home_pos       = state_reg.elec_pos;

  // source selects, already flops inside prio_select
  assign mech_sensor_sel     = select.mech_sensor;
  assign coord_sensor_sel    = select.coord_sensor;
  assign jog_home_sensor_sel = select.jog_home_sensor;
  assign limit_enable        = select.limit_on;
  assign protect_enable      = select.protect_on;

  // ----------------------------------------------------------------------
  // limitations
  // ----------------------------------------------------------------------
  // wrap ranges, gearing and motion profiles live elsewhere; this block
  // only says whether coordinates hold and which home they centre on.
  // write endurance of the home store is not counted here.
  // a homing move ended by abort leaves the old home in force.

endmodule

// ==== verification/home_monitor.sv ====
`timescale 1ns/1ps

module home_monitor #(
  parameter int POS_W = 32
) (
  input wire logic                     clk_sys,
  input wire logic                     rst,
  input wire logic signed [POS_W-1:0]  preset_value,
  input wire logic                     sensor_factory_home,
  input wire logic                     tool_clear_cmd,
  input wire logic                     fieldbus_clear_cmd,
  input wire logic                     elec_home_request,
  input wire logic signed [POS_W-1:0]  cmd_position_in,
  input wire logic                     move_req,
  input wire home_mgr_pkg::move_kind_t move_kind,
  input wire logic                     homing_done,
  input wire logic                     coords_valid_out,
  input wire logic                     factory_home_flag,
  input wire logic                     user_home_flag,
  input wire logic                     elec_home_active,
  input wire logic                     move_accept,
  input wire logic                     move_reject,
  input wire logic                     nvm_write,
  input wire logic                     pos_load,
  input wire logic signed [POS_W-1:0]  pos_load_value,
  input wire logic signed [POS_W-1:0]  elec_home_pos
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // multi-step events
  // ----------------------------------------------------------------------
  sequence s_home_go;
    move_req && move_kind == home_mgr_pkg::MOVE_HOMING ##1 move_accept;
  endsequence
  // a one-cycle blip on the request is not judged
  sequence s_elec_rise;
    $rose(elec_home_request) ##1 elec_home_request;
  endsequence
  sequence s_elec_fall;
    $fell(elec_home_request) ##1 !elec_home_request;
  endsequence

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_load_value: assert property (
    pos_load |-> pos_load_value == $past(preset_value))
    else $error("load value differs from preset");
  a_nvm_user_flag: assert property (
    nvm_write |-> user_home_flag)
    else $error("home commit without user home");
  a_hs_unset: assert property (
    move_req && move_kind == home_mgr_pkg::MOVE_HS_HOMING && !coords_valid_out |=> move_reject)
    else $error("fast homing taken while unset");
  a_hs_elec: assert property (
    move_req && move_kind == home_mgr_pkg::MOVE_HS_HOMING && elec_home_active
      && elec_home_request |=> move_reject)
    else $error("fast homing taken on electrical home");
  a_homing_unset: assert property (
    s_home_go |-> !coords_valid_out)
    else $error("coordinates valid during homing");
  a_done_restore: assert property (
    homing_done |=> coords_valid_out && user_home_flag && nvm_write)
    else $error("homing end did not restore home");
  a_elec_capture: assert property (
    s_elec_rise |=> elec_home_active && elec_home_pos == $past(cmd_position_in, 2))
    else $error("electrical home not captured");
  a_elec_clear: assert property (
    s_elec_fall |=> !elec_home_active)
    else $error("electrical home not cleared");
  a_factory_follow: assert property (
    !$past(rst) |-> factory_home_flag == $past(sensor_factory_home))
    else $error("factory flag not following sensor");
  a_fieldbus_keep: assert property (
    fieldbus_clear_cmd && user_home_flag && !tool_clear_cmd && !move_req |=> user_home_flag)
    else $error("fieldbus cleared user home");
endmodule

// ==== verification/host_model.sv ====
`timescale 1ns/1ps

module host_model #(
  parameter int DLY = 5
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     move_req,
  input  wire home_mgr_pkg::move_kind_t move_kind,
  input  wire logic                     move_accept,
  input  wire logic                     homing_abort,
  output logic                          homing_done
);
  // ----------------------------------------------------------------------
  // homing motion stand-in
  // ----------------------------------------------------------------------
  home_mgr_pkg::move_kind_t kind_reg;
  int                       cnt_reg;

  // ends an accepted homing move DLY cycles later; an abort drops it silently
  always_ff @(posedge clk_sys) begin
    homing_done <= 1'b0;
    if (move_req)
      kind_reg <= move_kind;
    if (rst || homing_abort)
      cnt_reg <= 0;
    else if (move_accept && kind_reg == home_mgr_pkg::MOVE_HOMING)
      cnt_reg <= DLY;
    else if (cnt_reg == 1) begin
      cnt_reg     <= 0;
      homing_done <= 1'b1;
    end else if (cnt_reg > 1)
      cnt_reg <= cnt_reg - 1;
  end
endmodule

// ==== verification/tb_coordinate_home_manager.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end

module tb_coordinate_home_manager;
  localparam logic [6:0] PRE = 7'h01, TOOL = 7'h02, FBC = 7'h04, RES = 7'h08;
  localparam logic [6:0] REQ = 7'h10, LOAD = 7'h20, ABT = 7'h40;
  logic                     clk_sys, rst, fh, req, cv, ff, uf, ea, ma, mr, nw, pl, done, uh;
  logic [6:0]               p;
  logic [4:0]               sel;
  logic signed [31:0]       pv, cp, nd, plv, ep;
  home_mgr_pkg::settings_t  st;
  home_mgr_pkg::move_kind_t mk;
  int                       err_total, check_count;

  coordinate_home_manager coordinate_home_manager_i (
    .clk_sys(clk_sys), .rst(rst), .abs_permit(st.abs_permit), .prio_mech(st.prio_mech),
    .prio_coord(st.prio_coord), .prio_jog_home(st.prio_jog_home), .ovr_limit(st.ovr_limit),
    .ovr_protect(st.ovr_protect), .settings_load(p[5]), .preset_value(pv),
    .sensor_factory_home(fh), .sensor_user_home(uh), .preset_cmd(p[0]),
    .tool_clear_cmd(p[1]), .fieldbus_clear_cmd(p[2]), .resolution_change(p[3]),
    .elec_home_request(req), .cmd_position_in(cp), .move_req(p[4]), .move_kind(mk),
    .homing_done(done), .homing_abort(p[6]), .coords_valid_out(cv),
    .factory_home_flag(ff), .user_home_flag(uf), .elec_home_active(ea), .move_accept(ma),
    .move_reject(mr), .nvm_write(nw), .nvm_home_data(nd), .pos_load(pl),
    .pos_load_value(plv), .elec_home_pos(ep), .mech_sensor_sel(sel[4]),
    .coord_sensor_sel(sel[3]), .jog_home_sensor_sel(sel[2]), .limit_enable(sel[1]),
    .protect_enable(sel[0]));
  host_model host_model_i (.clk_sys(clk_sys), .rst(rst), .move_req(p[4]), .move_kind(mk),
    .move_accept(ma), .homing_abort(p[6]), .homing_done(done));

  always #5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // a spare cycle up front keeps two pulses from touching p in one step
  task pulse(input logic [6:0] v);
    @(negedge clk_sys);
    p = v;
    @(negedge clk_sys);
    p = 7'h00;
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task t_prio;
    `CHK(cv, 1'b0)
    `CHK(ff, 1'b0)
    `CHK(sel, 5'h1F)
    for (int i = 0; i < 5; i++) begin
      st = 6'h01 << i;
      pulse(LOAD);
      @(negedge clk_sys);
      `CHK(sel, ~st[4:0])
    end
  endtask
  task t_unset;
    mk = home_mgr_pkg::MOVE_HS_HOMING;
    pulse(REQ);
    `CHK(mr, 1'b1)
    mk = home_mgr_pkg::MOVE_ABS;
    pulse(REQ);
    `CHK({ma, mr}, 2'h1)
    st = 6'h20;
    pulse(LOAD);
    pulse(REQ);
    `CHK({ma, mr}, 2'h2)
    st = 6'h00;
    pulse(LOAD);
  endtask
  task t_preset;
    pv = 32'h80000000;
    pulse(PRE);
    `CHK({pl, plv}, {1'b1, pv})
    `CHK({nw, nd}, {1'b1, pv})
    `CHK({uf, cv}, 2'h3)
    @(negedge clk_sys);
    `CHK({pl, nw}, 2'h0)
    pulse(REQ);
    `CHK(ma, 1'b1)
  endtask
  task t_homing;
    mk = home_mgr_pkg::MOVE_HOMING;
    pulse(REQ);
    `CHK({ma, cv}, 2'h2)
    mk = home_mgr_pkg::MOVE_ABS;
    pulse(REQ);
    `CHK(mr, 1'b1)
    for (int n = 0; n < 20 && cv !== 1'b1; n++)
      @(negedge clk_sys);
    `CHK({cv, uf}, 2'h3)
    mk = home_mgr_pkg::MOVE_HS_HOMING;
    pulse(REQ);
    `CHK(ma, 1'b1)
    pulse(ABT);
    repeat (3) @(negedge clk_sys);
    `CHK(cv, 1'b1)
  endtask
  task t_elec;
    cp  = 32'h12345678;
    req = 1'b1;
    @(negedge clk_sys);
    cp = 32'h0000ABCD;
    repeat (3) begin
      @(negedge clk_sys);
      `CHK(nw, 1'b0)
    end
    `CHK({ea, ep}, {1'b1, 32'h12345678})
    pulse(REQ);
    `CHK(mr, 1'b1)
    pv = 32'h7FFFFFFF;
    pulse(PRE);
    @(negedge clk_sys);
    `CHK({ep, plv}, {pv, pv})
    req = 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK(ea, 1'b0)
  endtask
  task t_clear;
    pulse(FBC);
    @(negedge clk_sys);
    `CHK(uf, 1'b1)
    pulse(TOOL);
    @(negedge clk_sys);
    `CHK({uf, cv}, 2'h0)
    pv = 32'h00000005;
    pulse(PRE);
    pulse(RES);
    @(negedge clk_sys);
    `CHK(cv, 1'b0)
    pv = 32'h00000000;
    pulse(PRE);
    pulse(RES);
    @(negedge clk_sys);
    `CHK(cv, 1'b1)
    fh = 1'b1;
    pulse(TOOL);
    @(negedge clk_sys);
    `CHK(ff, 1'b1)
    `CHK(cv, 1'b1)
    uh = 1'b1;
    @(negedge clk_sys);
    `CHK(uf, 1'b1)
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    {clk_sys, fh, req, p, st, pv, cp} = '0;
    {rst, uh, err_total, check_count} = '0;
    mk = home_mgr_pkg::MOVE_NONE;
    rst = 1'b1;
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    t_prio();
    t_unset();
    t_preset();
    t_homing();
    t_elec();
    t_clear();
    give_verdict();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule

bind coordinate_home_manager home_monitor #(.POS_W(POS_W)) home_monitor_i (
  .clk_sys(clk_sys), .rst(rst), .preset_value(preset_value),
  .sensor_factory_home(sensor_factory_home), .tool_clear_cmd(tool_clear_cmd),
  .fieldbus_clear_cmd(fieldbus_clear_cmd), .elec_home_request(elec_home_request),
  .cmd_position_in(cmd_position_in), .move_req(move_req), .move_kind(move_kind),
  .homing_done(homing_done), .coords_valid_out(coords_valid_out),
  .factory_home_flag(factory_home_flag), .user_home_flag(user_home_flag),
  .elec_home_active(elec_home_active), .move_accept(move_accept), .move_reject(move_reject),
  .nvm_write(nvm_write), .pos_load(pos_load), .pos_load_value(pos_load_value),
  .elec_home_pos(elec_home_pos));
